/* File: include/zcd_pkg.sv */
// Purpose: Shared constants for the zero-cross logic output block
// Assumes: APB slave, 32-bit data, one register word per offset
// Notes: Byte address of each register is four times its index

package zcd_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [11:0] CROSSING_CONTROL_REG_IDX = 12'h91f;
	localparam logic [11:0] IRQ_STATUS_IDX = 12'h920;
	localparam logic [11:0] IRQ_MASK_IDX = 12'h921;
	localparam logic [11:0] SYS_CONTROL_IDX = 12'h922;
	localparam logic [13:0] CROSSING_CONTROL_REG_ADDR = {CROSSING_CONTROL_REG_IDX, 2'b00};
	localparam logic [13:0] IRQ_STATUS_ADDR = {IRQ_STATUS_IDX, 2'b00};
	localparam logic [13:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX, 2'b00};
	localparam logic [13:0] SYS_CONTROL_ADDR = {SYS_CONTROL_IDX, 2'b00};

	// ****************************************
	// Control field positions
	// ****************************************
	localparam int SOFTWARE_ENABLE_POS = 7;
	localparam int OUTPUT_POS = 5;
	localparam int POLARITY_POS = 4;
	localparam int RISING_ENABLE_POS = 1;
	localparam int FALLING_ENABLE_POS = 0;

	// ****************************************
	// System control field positions
	// ****************************************
	localparam int CROSSING_IRQ_ENABLE_POS = 0;
	localparam int CROSSING_IRQ_PRIORITY_POS = 1;
	localparam int PRIORITY_LEVELS_ENABLE_POS = 2;
	localparam int PERIPHERAL_IRQ_ENABLE_POS = 3;
	localparam int GLOBAL_IRQ_ENABLE_POS = 4;
	localparam int MODULE_DISABLE_POS = 5;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [5:0] SYS_CONTROL_RESET = 6'h00;
	localparam logic MASK_RESET = 1'b0;

endpackage

/* File: logic/zcd_logic_output.sv */
// Purpose: Polarity-adjusted zero-cross logic output with edge interrupt
// Assumes: Sink indication is asynchronous to clk
// Notes: Notes on behaviour below
// Notes on behaviour
// - Output high while sink active
// - Polarity bit inverts the output
// - Output readable as status bit
// - Output exported to timer gate, clock, reset
// - Separate rising and falling edge detectors
// - Enabled edge sets crossing interrupt flag
// - Edges detected after polarity adjustment
// - Polarity change sets flag only if that edge is enabled
// - Set wins over simultaneous clear
// - Interrupt needs mask, crossing, peripheral and global enables plus one edge enable
// - Priority bit picks high or low line when priority levels enabled, else high
// - Fuse selects always-on or software enable
// - Works unchanged during sleep
// - Control register layout and reset values
// - Module disable bit also switches off, only when fuse selects software enable

`timescale 1ns/10ps

module zcd_logic_output
	import zcd_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic sinkActive,
	input wire logic fuseSoftwareControl,
	input wire logic sleepMode,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [13:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic detectorActive,
	output logic crossingOut,
	output logic crossingIrqFlag,
	output logic irqHigh,
	output logic irqLow,
	output logic irq
);

	// ****************************************
	// Declarations
	// ****************************************
	logic sinkMeta;
	logic sinkSync;
	logic next_sinkSync;
	logic polaritySelect;
	logic next_polaritySelect;
	logic softwareEnableBit;
	logic next_softwareEnableBit;
	logic risingEdgeIrqEnable;
	logic next_risingEdgeIrqEnable;
	logic fallingEdgeIrqEnable;
	logic next_fallingEdgeIrqEnable;
	logic [5:0] sysControl;
	logic [5:0] next_sysControl;
	logic irqMask;
	logic next_irqMask;
	logic next_crossingIrqFlag;
	logic outPrev;
	logic next_outPrev;
	logic next_crossingOut;
	logic [31:0] readControl;
	logic [31:0] readStatus;
	logic [31:0] readMask;
	logic [31:0] readSys;
	logic [31:0] readWord;
	logic [31:0] next_prdata;
	logic enabled;
	logic rawSink;
	logic adjusted;
	logic risePulse;
	logic fallPulse;
	logic [1:0] edgeSeen;
	logic [1:0] edgeEnable;
	logic [1:0] edgeArmed;
	logic setFlag;
	logic wrEn;
	logic rdEn;
	logic hitControl;
	logic hitStatus;
	logic hitMask;
	logic hitSys;
	logic wrControl;
	logic wrMask;
	logic wrSys;
	logic addrOk;
	logic clearFlag;
	logic unmasked;

	// ****************************************
	// Bus decode
	// ****************************************
	assign wrEn = psel && penable && pwrite;
	assign rdEn = psel && !penable && !pwrite;
	assign hitControl = (paddr == CROSSING_CONTROL_REG_ADDR);
	assign hitStatus = (paddr == IRQ_STATUS_ADDR);
	assign hitMask = (paddr == IRQ_MASK_ADDR);
	assign hitSys = (paddr == SYS_CONTROL_ADDR);
	assign addrOk = hitControl || hitStatus || hitMask || hitSys;
	assign wrControl = wrEn && hitControl;
	assign wrMask = wrEn && hitMask;
	assign wrSys = wrEn && hitSys;
	assign clearFlag = wrEn && hitStatus && pwdata[0];

	// ****************************************
	// Bus response
	// ****************************************
	// No wait states
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addrOk;

	// ****************************************
	// Enable
	// ****************************************
	// Sleep does not gate anything here
	assign enabled = (!fuseSoftwareControl || softwareEnableBit) &&
		!(fuseSoftwareControl && sysControl[MODULE_DISABLE_POS]);
	assign detectorActive = enabled;
	// Raw sink forced low when off
	assign rawSink = sinkSync && enabled;

	// ****************************************
	// Polarity and edges
	// ****************************************
	assign adjusted = rawSink ^ polaritySelect;
	assign risePulse = adjusted && !outPrev;
	assign fallPulse = !adjusted && outPrev;

	// ****************************************
	// Edge qualification
	// ****************************************
	// Bit order matches the enable field positions
	assign edgeSeen = {risePulse, fallPulse};
	assign edgeEnable = {risingEdgeIrqEnable, fallingEdgeIrqEnable};
	for (genvar gi = 0; gi < 2; gi++) begin : g_edge
		assign edgeArmed[gi] = edgeSeen[gi] && edgeEnable[gi];
	end
	// Polarity writes reach the flag through the same edge path
	assign setFlag = |edgeArmed;

	// ****************************************
	// Interrupt routing
	// ****************************************
	assign unmasked = crossingIrqFlag && irqMask && sysControl[CROSSING_IRQ_ENABLE_POS] &&
		(risingEdgeIrqEnable || fallingEdgeIrqEnable) && sysControl[PERIPHERAL_IRQ_ENABLE_POS] &&
		sysControl[GLOBAL_IRQ_ENABLE_POS];
	assign irq = unmasked;
	assign irqHigh = unmasked && (!sysControl[PRIORITY_LEVELS_ENABLE_POS] ||
		sysControl[CROSSING_IRQ_PRIORITY_POS]);
	assign irqLow = unmasked && sysControl[PRIORITY_LEVELS_ENABLE_POS] &&
		!sysControl[CROSSING_IRQ_PRIORITY_POS];

	// ****************************************
	// Synchroniser
	// ****************************************
	// First stage is read only by the second
	always_comb begin
		next_sinkSync = sinkMeta;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sinkMeta <= 1'b0;
			sinkSync <= 1'b0;
		end else begin
			sinkMeta <= sinkActive;
			sinkSync <= next_sinkSync;
		end
	end

	// ****************************************
	// Output register
	// ****************************************
	always_comb begin
		next_outPrev = adjusted;
		next_crossingOut = adjusted;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			outPrev <= 1'b0;
			crossingOut <= 1'b0;
		end else begin
			outPrev <= next_outPrev;
			crossingOut <= next_crossingOut;
		end
	end

	// ****************************************
	// Control register
	// ****************************************
	always_comb begin
		next_polaritySelect = polaritySelect;
		next_softwareEnableBit = softwareEnableBit;
		next_risingEdgeIrqEnable = risingEdgeIrqEnable;
		next_fallingEdgeIrqEnable = fallingEdgeIrqEnable;
		if (wrControl) begin
			next_softwareEnableBit = pwdata[SOFTWARE_ENABLE_POS];
			next_polaritySelect = pwdata[POLARITY_POS];
			next_risingEdgeIrqEnable = pwdata[RISING_ENABLE_POS];
			next_fallingEdgeIrqEnable = pwdata[FALLING_ENABLE_POS];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			polaritySelect <= CONTROL_RESET[POLARITY_POS];
			softwareEnableBit <= CONTROL_RESET[SOFTWARE_ENABLE_POS];
			risingEdgeIrqEnable <= CONTROL_RESET[RISING_ENABLE_POS];
			fallingEdgeIrqEnable <= CONTROL_RESET[FALLING_ENABLE_POS];
		end else begin
			polaritySelect <= next_polaritySelect;
			softwareEnableBit <= next_softwareEnableBit;
			risingEdgeIrqEnable <= next_risingEdgeIrqEnable;
			fallingEdgeIrqEnable <= next_fallingEdgeIrqEnable;
		end
	end

	// ****************************************
	// Mask register
	// ****************************************
	always_comb begin
		next_irqMask = irqMask;
		if (wrMask) begin
			next_irqMask = pwdata[0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irqMask <= MASK_RESET;
		end else begin
			irqMask <= next_irqMask;
		end
	end

	// ****************************************
	// System control register
	// ****************************************
	always_comb begin
		next_sysControl = sysControl;
		if (wrSys) begin
			next_sysControl = pwdata[5:0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sysControl <= SYS_CONTROL_RESET;
		end else begin
			sysControl <= next_sysControl;
		end
	end

	// ****************************************
	// Interrupt flag
	// ****************************************
	// Set after clear so set wins
	always_comb begin
		next_crossingIrqFlag = crossingIrqFlag;
		if (clearFlag) begin
			next_crossingIrqFlag = 1'b0;
		end
		if (setFlag) begin
			next_crossingIrqFlag = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			crossingIrqFlag <= 1'b0;
		end else begin
			crossingIrqFlag <= next_crossingIrqFlag;
		end
	end

	// ****************************************
	// Readback
	// ****************************************
	always_comb begin
		readControl = 32'h0;
		readControl[SOFTWARE_ENABLE_POS] = softwareEnableBit;
		readControl[OUTPUT_POS] = crossingOut;
		readControl[POLARITY_POS] = polaritySelect;
		readControl[RISING_ENABLE_POS] = risingEdgeIrqEnable;
		readControl[FALLING_ENABLE_POS] = fallingEdgeIrqEnable;
	end
	assign readStatus = {31'h0, crossingIrqFlag};
	assign readMask = {31'h0, irqMask};
	assign readSys = {26'h0, sysControl};

	// Unmapped addresses read as zero
	always_comb begin
		readWord = 32'h0;
		unique case (paddr)
			CROSSING_CONTROL_REG_ADDR: begin
				readWord = readControl;
			end
			IRQ_STATUS_ADDR: begin
				readWord = readStatus;
			end
			IRQ_MASK_ADDR: begin
				readWord = readMask;
			end
			SYS_CONTROL_ADDR: begin
				readWord = readSys;
			end
			default: begin
				readWord = 32'h0;
			end
		endcase
	end

	// Captured in the setup cycle
	always_comb begin
		next_prdata = prdata;
		if (rdEn) begin
			next_prdata = readWord;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h0;
		end else begin
			prdata <= next_prdata;
		end
	end

endmodule

/* File: test/zcd_sink_model.sv */
// Purpose: Analog sink stage stand-in
// Assumes: Level changes arrive unrelated to clk
// Notes: LAG sets a prompt or slow answer
`timescale 1ns/10ps
module zcd_sink_model #(parameter int LAG = 7) (
	input wire logic want,
	output logic sinkActive
);
	initial sinkActive = 1'h0;
	// Pin has no pull-up, level follows the stage only
	always @(want) sinkActive <= #LAG want;
endmodule

/* File: test/zcd_logic_output_sva.sv */
// Purpose: Port checks for zcd_logic_output
// Assumes: One clock, nrst async low
// Notes: Bound after endmodule
`timescale 1ns/10ps
module zcd_logic_output_sva
	import zcd_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [13:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic crossingOut,
	input wire logic crossingIrqFlag,
	input wire logic irqHigh,
	input wire logic irqLow,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire acc = psel && penable;
	wire hit = paddr inside {CROSSING_CONTROL_REG_ADDR, IRQ_STATUS_ADDR, IRQ_MASK_ADDR, SYS_CONTROL_ADDR};
	wire clr = acc && pwrite && paddr == IRQ_STATUS_ADDR && pwdata[0];
	sequence clearThenQuiet;
		clr ##1 !$changed(crossingOut);
	endsequence
	a_flag_sticky: assert property ($fell(crossingIrqFlag) |-> $past(clr))
		else $error("flag dropped");
	a_flag_edge: assert property ($rose(crossingIrqFlag) |-> $changed(crossingOut))
		else $error("flag without edge");
	a_clear_works: assert property (clearThenQuiet |-> !crossingIrqFlag)
		else $error("clear lost");
	a_out_status: assert property (acc && !pwrite && paddr == CROSSING_CONTROL_REG_ADDR
		|-> prdata[OUTPUT_POS] == $past(crossingOut))
		else $error("status bit");
	a_irq_split: assert property (irq == (irqHigh || irqLow))
		else $error("irq split");
	a_irq_single: assert property (!(irqHigh && irqLow))
		else $error("both lines");
	a_irq_flag: assert property (irq |-> crossingIrqFlag)
		else $error("irq without flag");
	a_unmapped_err: assert property (acc |-> pslverr == !hit)
		else $error("slave error");
endmodule
bind zcd_logic_output zcd_logic_output_sva u_sva (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pslverr, .crossingOut, .crossingIrqFlag, .irqHigh, .irqLow, .irq);

/* File: test/zcd_logic_output_tb.sv */
// Purpose: Self-checking bench for zcd_logic_output
// Assumes: Fuse clear, detector always on, until t_fuse sets the fuse
// Notes: Sleep held high throughout
`timescale 1ns/10ps
module zcd_logic_output_tb import zcd_pkg::*;;
	logic clk = 1'h0, nrst = 1'h0, want = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, fuse = 1'h0;
	logic [13:0] paddr = 14'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, detectorActive, crossingOut, crossingIrqFlag, irqHigh, irqLow, irq, sinkActive, err;
	int error_cnt = 0, total_checks = 0, cycles = 0;
	zcd_sink_model #(.LAG(7)) sink (.want, .sinkActive);
	zcd_logic_output dut (.clk, .nrst, .sinkActive, .fuseSoftwareControl(fuse), .sleepMode(1'h1),
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .detectorActive,
		.crossingOut, .crossingIrqFlag, .irqHigh, .irqLow, .irq);
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			error_cnt++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask
	task automatic t_regs();
		xfer(1'h0, CROSSING_CONTROL_REG_ADDR, 32'h0);
		chk(rd, 32'h0);
		chk(detectorActive, 1'h1);
		xfer(1'h1, CROSSING_CONTROL_REG_ADDR, 32'h93);
		xfer(1'h0, CROSSING_CONTROL_REG_ADDR, 32'h0);
		chk(rd, 32'hb3);
		chk(crossingIrqFlag, 1'h1);
		xfer(1'h1, IRQ_STATUS_ADDR, 32'h1);
		chk(crossingIrqFlag, 1'h0);
		xfer(1'h0, 14'h24c0, 32'h0);
		chk({err, rd[30:0]}, 32'h80000000);
	endtask
	task automatic t_sink();
		xfer(1'h1, CROSSING_CONTROL_REG_ADDR, 32'h2);
		xfer(1'h1, IRQ_MASK_ADDR, 32'h1);
		xfer(1'h1, SYS_CONTROL_ADDR, 32'h19);
		chk(crossingIrqFlag, 1'h0);
		want <= 1'h1;
		repeat (8) @(posedge clk);
		chk(crossingOut, 1'h1);
		chk({irq, irqHigh, irqLow, crossingIrqFlag}, 4'hd);
		xfer(1'h1, SYS_CONTROL_ADDR, 32'h1d);
		chk({irqHigh, irqLow}, 2'h1);
		xfer(1'h1, SYS_CONTROL_ADDR, 32'h1f);
		chk({irqHigh, irqLow}, 2'h2);
		xfer(1'h1, IRQ_MASK_ADDR, 32'h0);
		chk(irq, 1'h0);
		xfer(1'h1, IRQ_STATUS_ADDR, 32'h1);
		xfer(1'h1, CROSSING_CONTROL_REG_ADDR, 32'h11);
		xfer(1'h0, CROSSING_CONTROL_REG_ADDR, 32'h0);
		chk(rd, 32'h11);
		chk(crossingIrqFlag, 1'h1);
		xfer(1'h1, IRQ_STATUS_ADDR, 32'h1);
		want <= 1'h0;
		repeat (8) @(posedge clk);
		chk({crossingOut, crossingIrqFlag}, 2'h2);
	endtask
	task automatic t_fuse();
		nrst <= 1'h0;
		fuse <= 1'h1;
		repeat (2) @(posedge clk);
		nrst <= 1'h1;
		@(posedge clk);
		chk(detectorActive, 1'h0);
		chk(crossingOut, 1'h0);
		xfer(1'h1, CROSSING_CONTROL_REG_ADDR, 32'h80);
		chk(detectorActive, 1'h1);
		xfer(1'h1, SYS_CONTROL_ADDR, 32'h20);
		chk(detectorActive, 1'h0);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'h1;
		t_regs();
		t_sink();
		t_fuse();
		summarize();
	end
endmodule
